// File: test_tof_sensor_startup_sequencer.sv
`timescale 1ns/10ps
module test_tof_sensor_startup_sequencer
    import tss_pkg::*;
;
    logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic streaming, laneFour, frameTrig, firstData;
    logic [11:0] paddr = 0;
    logic [15:0] pktBytes, integCycles = 16'h000A;
    logic [31:0] pwdata = 0, prdata, rd;
    tss_dev_state_t devState;
    int n_errors = 0, comparisons = 0, cyc = 0, tStr = 0, tTrig = 0, tData = 0, tSw = 0;
    tss_link_if lnk ();
    tss_host_end #(.STREAM_DLY(200)) tss_host_end_i (.link(lnk), .*);
    tss_sensor_end tss_sensor_end_i (.link(lnk), .*);
    tss_link_assertions tss_link_assertions_i (.clk_sys, .sys_rst, .sda(lnk.sda),
        .resetPinN(lnk.resetPinN), .scl(lnk.scl), .hostSdaOen(lnk.hostSdaOen),
        .devSdaOen(lnk.devSdaOen));
    initial forever #25 clk_sys = ~clk_sys;
    // Pulses are too short to catch by polling, so their cycles are logged.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (devState === DEV_STREAM && tStr == 0) tStr <= cyc;
        if (devState === DEV_SW_SB && tSw == 0) tSw <= cyc;
        if (frameTrig === 1'b1) tTrig <= cyc;
        if (firstData === 1'b1) tData <= cyc;
    end
    task automatic final_report();
        $display("%0d compared, %0d wrong", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) $display("unexpected %s: expected %h seen %h", s, e, g);
        if (g !== e) n_errors++;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk_sys) penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1 && ++i < 99);
        chk("pready", 1, pready);
        if (pready !== 1'b1) final_report();
        {rd, err, psel, penable} <= {prdata, pslverr, 2'b00};
        @(posedge clk_sys);
    endtask
    task automatic poll(input logic [31:0] s, input logic [31:0] m);
        int i = 0;
        do apb(0, APB_STATUS, 0); while ((rd & m) !== s && ++i < 9000);
        chk("status", s, rd & m);
        if ((rd & m) !== s) final_report();
    endtask
    task automatic t_reset();
        sys_rst <= 1;
        repeat (6) @(posedge clk_sys);
        sys_rst <= 0;
        @(posedge clk_sys);
        chk("laneFour", 1, laneFour);
        poll(32'h001, 32'hFFF);
        apb(0, 12'h0F0, 0);
        chk("pslverr", 1, err);
        $display("reset done");
    endtask
    task automatic t_start();
        apb(1, APB_LOT, 32'h2C0);
        apb(0, APB_LOT, 0);
        chk("lot", 32'h2C0, rd);
        apb(1, APB_CTRL, 32'h1);
        poll(32'h020, 32'hFFF);
        chk("devState", DEV_SW_SB, devState);
        apb(1, APB_CMD, {8'h00, REG_LANE, 8'h00});
        poll(32'h020, 32'hFFF);
        chk("laneFour", 0, laneFour);
        $display("start done");
    endtask
    task automatic t_stream();
        apb(1, APB_CTRL, 32'h2);
        poll(32'h100, 32'h1FF);
        chk("streaming", 1, streaming);
        chk("pktBytes", LINE_PIXELS / PIX_PER_UNIT * BYTES_PER_UNIT, pktBytes);
        chk("stream gap", 1, tStr - tSw >= 200);
        apb(1, APB_CTRL, 0);
        poll(32'h020, 32'hFFF);
        chk("streaming", 0, streaming);
        chk("trigger", tStr, tTrig);
        chk("data", tTrig + integCycles + 1, tData);
        $display("stream done");
    endtask
    initial begin
        t_reset();
        t_start();
        t_stream();
        t_reset();
        final_report();
    end
endmodule

// File: tss_host_end.sv
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
// Contract
// [R01] Video payload is whole three-byte pixel pairs.
// [R02] Host redoes full initialization after every reset.
// [R03] Reset pin held low at least 100 us.
// [R04] Reset released only with input clock running.
// [R05] Releasing reset pin enters sensor standby.
// [R06] Wait 100 us after release before commanding.
// [R07] Write fixed input-clock settings in sensor standby.
// [R08] Writing standby zero enters software standby.
// [R09] Write full initialization map in software standby.
// [R10] Initialization writes keep their listed order.
// [R11] Early lots get two extra register writes.
// [R12] Set operating mode registers in software standby.
// [R13] Set output mode, phases, integration in standby.
// [R14] Set phase shifts before enabling streaming.
// [R15] Writing stream one starts video streaming.
// [R16] At least 12 ms from standby clear to stream.
// [R17] First data within 2.8 ms plus integration.
// [R18] Output link settings only in software standby.
// [R19] Lane bit selects two or four lanes.
// [R20] Rate tables updated for chosen lane rate.
// [R21] Mode changes never during streaming.
// [R22] Software trigger mode fires first frame on stream.
// [R23] Device ignores bus while reset pin low.
// [R24] Host steps the phases strictly in order.
module tss_host_end
    import tss_pkg::*;
#(
    parameter int STREAM_DLY = STREAM_DLY_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    tss_link_if.host         link
);
    // All wait counters share one width, so it must hold the longest of the three waits.
    localparam int LONGEST = STREAM_DLY > RST_HOLD_CYC ? STREAM_DLY : RST_HOLD_CYC;
    localparam int CW      = $clog2((LONGEST > FIRST_CMD_CYC ? LONGEST : FIRST_CMD_CYC) + 1);

    typedef enum logic [8:0] {
        H_IDLE = 9'h001,
        H_RST = 9'h002,
        H_WAIT = 9'h004,
        H_FIXCLK = 9'h008,
        H_LEAVE = 9'h010,
        H_SWSB = 9'h020,
        H_EARLY = 9'h040,
        H_GO = 9'h080,
        H_STREAM = 9'h100
    } tss_host_state_t;

    typedef enum logic [3:0] {
        M_IDLE = 4'h1,
        M_START = 4'h2,
        M_BITS = 4'h4,
        M_STOP = 4'h8
    } tss_mst_state_t;

    typedef struct packed {
        tss_host_state_t state;
        tss_mst_state_t  mst;
        logic [CW-1:0]   waitCnt, t8Cnt;
        logic            t8Run, t8Done, launched;
        logic [3:0]      idx;
        logic            cmdPend, ctlStream, nack;
        logic [23:0]     cmd;
        logic [15:0]     lot;
        logic [31:0]     prdata;
        logic [1:0]      q;
        logic [7:0]      div;
        logic [5:0]      bitIdx;
        logic [35:0]     tx;
        logic            scl, sdaLow, resetPinN, sdaMeta, sdaSync;
    } tss_host_t;

    tss_host_t   r_reg;
    tss_host_t   r_next;
    logic        wrGo;
    logic        wrDone;
    logic        tick;
    logic [15:0] wrAddr;
    logic [7:0]  wrData;
    logic        setup;
    logic        access;

    function automatic logic ackSlot(input logic [5:0] i);
        ackSlot = (i == 6'h08) || (i == 6'h11) || (i == 6'h1A) || (i == 6'h23);
    endfunction

    function automatic logic driveLow(input logic [35:0] tx, input logic [5:0] i);
        driveLow = !ackSlot(i) && !tx[6'h23 - i];
    endfunction

    always_comb begin
        r_next = r_reg;
        r_next.sdaMeta = link.sda;
        r_next.sdaSync = r_reg.sdaMeta;
        wrGo = 1'h0;
        wrAddr = 16'h0000;
        wrData = 8'h00;
        wrDone = r_reg.launched && r_reg.mst == M_IDLE;
        if (wrDone) begin
            r_next.launched = 1'h0;
        end
        setup = psel && !penable;
        access = psel && penable;

        // APB slave: read data captured in setup, writes applied in access.
        if (setup) begin
            case (paddr)
                APB_CTRL: r_next.prdata = {30'h0, r_reg.ctlStream, 1'h0};
                APB_STATUS: r_next.prdata = {20'h0, r_reg.cmdPend, r_reg.nack,
                                             r_reg.mst != M_IDLE, r_reg.state};
                APB_CMD: r_next.prdata = {8'h00, r_reg.cmd};
                APB_LOT: r_next.prdata = {16'h0000, r_reg.lot};
                default: r_next.prdata = 32'h0000_0000;
            endcase
        end

        // Long waits are counted from standby clear onward. [R16]
        if (r_reg.t8Run && !r_reg.t8Done) begin
            r_next.t8Cnt = r_reg.t8Cnt + CW'(1);
            if (r_reg.t8Cnt == CW'(STREAM_DLY - 1)) begin
                r_next.t8Done = 1'h1;
            end
        end

        case (r_reg.state)
            H_IDLE: begin
                r_next.resetPinN = 1'h0;
                // clk_sys is running here, so the sensor clock is up first. [R04]
                if (access && pwrite && paddr == APB_CTRL && pwdata[CTRL_START]) begin
                    r_next.state = H_RST; // [R02]
                    r_next.waitCnt = '0;
                    r_next.nack = 1'h0;
                end
            end
            H_RST: begin
                r_next.waitCnt = r_reg.waitCnt + CW'(1);
                if (r_reg.waitCnt == CW'(RST_HOLD_CYC - 1)) begin // [R03]
                    r_next.resetPinN = 1'h1; // [R05]
                    r_next.waitCnt = '0;
                    r_next.state = H_WAIT;
                end
            end
            H_WAIT: begin
                r_next.waitCnt = r_reg.waitCnt + CW'(1);
                if (r_reg.waitCnt == CW'(FIRST_CMD_CYC - 1)) begin // [R06]
                    r_next.idx = 4'h0;
                    r_next.state = H_FIXCLK;
                end
            end
            H_FIXCLK: begin
                wrGo = 1'h1;
                wrAddr = FIXCLK_ADDR[r_reg.idx];
                wrData = FIXCLK_DATA[r_reg.idx]; // [R07]
                if (wrDone) begin
                    r_next.idx = r_reg.idx + 4'h1;
                    if (r_reg.idx == 4'(FIXCLK_N - 1)) begin
                        r_next.state = H_LEAVE; // [R24]
                    end
                end
            end
            H_LEAVE: begin
                wrGo = 1'h1;
                wrAddr = REG_STANDBY;
                wrData = STANDBY_OFF; // [R08]
                if (wrDone) begin
                    r_next.t8Run = 1'h1;
                    r_next.state = H_SWSB;
                end
            end
            H_SWSB: begin
                // Software's map, mode, output and rate writes go out one by one. [R09]
                wrGo = r_reg.cmdPend; // [R10]
                wrAddr = r_reg.cmd[23:8]; // [R12] [R13] [R14] [R18] [R20]
                wrData = r_reg.cmd[7:0];
                if (wrDone) begin
                    r_next.cmdPend = 1'h0;
                end else if (!r_reg.cmdPend && !r_reg.launched && r_reg.ctlStream) begin
                    r_next.idx = 4'h0;
                    r_next.state = H_EARLY;
                end
            end
            H_EARLY: begin
                if (r_reg.lot > LOT_EARLY_MAX || r_reg.idx == 4'h2) begin
                    r_next.state = H_GO;
                end else begin
                    wrGo = 1'h1;
                    wrAddr = EARLY_ADDR[r_reg.idx[0]];
                    wrData = EARLY_DATA[r_reg.idx[0]]; // [R11]
                    if (wrDone) begin
                        r_next.idx = r_reg.idx + 4'h1;
                    end
                end
            end
            H_GO: begin
                wrGo = r_reg.t8Done; // [R16]
                wrAddr = REG_STREAM;
                wrData = STREAM_ON; // [R15]
                if (wrDone) begin
                    r_next.state = H_STREAM;
                end
            end
            H_STREAM: begin
                // Leaving streaming first, so mode changes happen in standby. [R21]
                wrGo = !r_reg.ctlStream;
                wrAddr = REG_STREAM;
                wrData = STREAM_OFF;
                if (wrDone) begin
                    r_next.state = H_SWSB;
                end
            end
            default: r_next.state = H_IDLE;
        endcase

        if (access && pwrite) begin
            case (paddr)
                APB_CTRL: r_next.ctlStream = pwdata[CTRL_STREAM];
                APB_CMD: begin
                    // Taken only in software standby with the slot free.
                    if (r_reg.state == H_SWSB && !r_reg.cmdPend) begin
                        r_next.cmd = pwdata[23:0];
                        r_next.cmdPend = 1'h1;
                    end
                end
                APB_LOT: r_next.lot = pwdata[15:0];
                default: r_next.lot = r_reg.lot;
            endcase
        end

        if (wrGo && !r_reg.launched && r_reg.mst == M_IDLE) begin
            r_next.launched = 1'h1;
            r_next.tx = {SLAVE_ADDR, 1'h0, 1'h1, wrAddr[15:8], 1'h1, wrAddr[7:0], 1'h1,
                         wrData, 1'h1};
            r_next.mst = M_START;
            r_next.q = 2'h0;
            r_next.div = 8'h00;
        end

        // Bit engine: four quarters per link clock period.
        tick = r_reg.div == 8'(QTR_CYC - 1);
        if (r_reg.mst != M_IDLE) begin
            r_next.div = tick ? 8'h00 : r_reg.div + 8'h01;
        end
        if (tick) begin
            r_next.q = r_reg.q + 2'h1;
            case (r_reg.mst)
                M_START: begin
                    // The low phase after a start lasts a full half period like every other.
                    case (r_reg.q)
                        2'h0: r_next.sdaLow = 1'h1;
                        2'h1: r_next.scl = 1'h0;
                        default: begin
                            r_next.q = 2'h0;
                            r_next.bitIdx = 6'h00;
                            r_next.sdaLow = driveLow(r_reg.tx, 6'h00);
                            r_next.mst = M_BITS;
                        end
                    endcase
                end
                M_BITS: begin
                    case (r_reg.q)
                        2'h0: r_next.scl = 1'h1;
                        2'h1: begin
                            if (ackSlot(r_reg.bitIdx) && r_reg.sdaSync) begin
                                r_next.nack = 1'h1;
                            end
                        end
                        2'h2: r_next.scl = 1'h0;
                        default: begin
                            if (r_reg.bitIdx == 6'(FRAME_BITS - 1)) begin
                                r_next.mst = M_STOP;
                                r_next.sdaLow = 1'h1;
                            end else begin
                                r_next.bitIdx = r_reg.bitIdx + 6'h01;
                                r_next.sdaLow = driveLow(r_reg.tx, r_reg.bitIdx + 6'h01);
                            end
                        end
                    endcase
                end
                M_STOP: begin
                    case (r_reg.q)
                        2'h0: r_next.scl = 1'h1;
                        2'h1: r_next.sdaLow = 1'h0;
                        default: r_next.mst = M_IDLE;
                    endcase
                end
                default: r_next.mst = M_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            r_reg <= '0;
            r_reg.state <= H_IDLE;
            r_reg.mst <= M_IDLE;
            r_reg.scl <= 1'h1;
            r_reg.sdaSync <= 1'h1;
            r_reg.sdaMeta <= 1'h1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata = r_reg.prdata;
    assign pready = access;
    assign pslverr = access && paddr != APB_CTRL && paddr != APB_STATUS
                     && paddr != APB_CMD && paddr != APB_LOT;
    assign link.resetPinN = r_reg.resetPinN;
    assign link.scl = r_reg.scl;
    assign link.hostSdaOut = 1'h0;
    assign link.hostSdaOen = !r_reg.sdaLow;
endmodule

// File: tss_link_assertions.sv
`timescale 1ns/10ps
module tss_link_assertions
    import tss_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic resetPinN,
    input wire logic scl,
    input wire logic sda,
    input wire logic hostSdaOen,
    input wire logic devSdaOen
);
    int lowN, relN;
    always_ff @(posedge clk_sys) begin
        lowN <= sys_rst || resetPinN ? 0 : lowN + 1;
        relN <= sys_rst || !resetPinN ? 0 : relN + 1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    rst_hold_a: assert property ($rose(resetPinN) |-> lowN >= RST_HOLD_CYC - 1)
        else $error("reset pin released early");
    first_cmd_a: assert property ($fell(sda) && scl |-> relN >= FIRST_CMD_CYC - 1)
        else $error("start sent too soon");
    quiet_rst_a: assert property (!resetPinN [*4] |-> devSdaOen) else $error("driven in reset");
    idle_link_a: assert property (!resetPinN |-> scl && hostSdaOen) else $error("link busy");
    scl_low_a: assert property ($fell(scl) |=> !scl [*3] ##1 scl) else $error("bad low phase");
    scl_high_a: assert property ($rose(scl) |=> scl [*3]) else $error("bad high phase");
    dev_edge_a: assert property ($changed(devSdaOen) |-> !scl) else $error("moved at high");
    dev_ack_a: assert property ($fell(devSdaOen) |=> !devSdaOen [*4]) else $error("short ack");
    cover property ($rose(resetPinN));
    cover property ($fell(sda) && scl);
    cover property ($fell(devSdaOen));
endmodule

// File: tss_link_if.sv
`timescale 1ns/10ps
interface tss_link_if;
    logic resetPinN;
    logic scl;
    logic hostSdaOut;
    logic hostSdaOen;
    logic devSdaOut;
    logic devSdaOen;
    logic sda;

    // Open-drain wire: low when either end drives low, else pulled high.
    assign sda = !((!hostSdaOen && !hostSdaOut) || (!devSdaOen && !devSdaOut));

    modport host (output resetPinN, output scl, output hostSdaOut, output hostSdaOen,
                  input sda);
    modport dev (input resetPinN, input scl, input sda, output devSdaOut,
                 output devSdaOen);
endinterface

// File: tss_pkg.sv
package tss_pkg;
    // Clocking and link timing.
    localparam int CLK_MHZ        = 20;
    localparam int CLK_PERIOD_NS  = 50;
    localparam int LINK_PERIOD_NS = 400;
    localparam int QTR_CYC        = LINK_PERIOD_NS / CLK_PERIOD_NS / 4;

    // Start-up timing, figures as printed, then cycle counts.
    localparam int  T_RST_HOLD_US   = 100;
    localparam int  T_FIRST_CMD_US  = 100;
    localparam int  T_STREAM_MS     = 12;
    localparam real T_FIRST_DATA_MS = 2.8;
    localparam int  RST_HOLD_CYC    = T_RST_HOLD_US * CLK_MHZ;
    localparam int  FIRST_CMD_CYC   = T_FIRST_CMD_US * CLK_MHZ;
    localparam int  STREAM_DLY_CYC  = T_STREAM_MS * 1000 * CLK_MHZ;
    localparam int  FIRST_DATA_CYC  = int'(T_FIRST_DATA_MS * 1000.0) * CLK_MHZ;

    // Two-wire control bus.
    localparam logic [6:0] SLAVE_ADDR = 7'h57;
    localparam int         FRAME_BITS = 36;

    // Device registers.
    localparam logic [15:0] REG_STANDBY = 16'h1000;
    localparam logic [15:0] REG_STREAM  = 16'h1001;
    localparam logic [15:0] REG_LANE    = 16'h1010;
    localparam logic [7:0]  STANDBY_RST = 8'h01;
    localparam logic [7:0]  STREAM_RST  = 8'h00;
    localparam logic [7:0]  LANE_RST    = 8'h03;
    localparam logic [7:0]  STANDBY_OFF = 8'h00;
    localparam logic [7:0]  STREAM_ON   = 8'h01;
    localparam logic [7:0]  STREAM_OFF  = 8'h00;
    localparam int          CTL_BIT     = 0;

    // Fixed input-clock settings written in sensor standby.
    localparam int          FIXCLK_N = 9;
    localparam logic [15:0] FIXCLK_ADDR [FIXCLK_N] = '{16'h1006, 16'h1007, 16'h1040,
        16'h1041, 16'h1042, 16'h1043, 16'h1044, 16'h1046, 16'h104A};
    localparam logic [7:0]  FIXCLK_DATA [FIXCLK_N] = '{8'h08, 8'h00, 8'h00, 8'h96,
        8'h01, 8'h00, 8'h00, 8'h01, 8'h01};

    // Extra pair for early production lots.
    localparam logic [15:0] LOT_EARLY_MAX = 16'h02C0;
    localparam logic [15:0] EARLY_ADDR [2] = '{16'h5108, 16'h5109};
    localparam logic [7:0]  EARLY_DATA [2] = '{8'h72, 8'h18};

    // RAW12 packing: two pixels travel in three bytes.
    localparam int PIX_PER_UNIT   = 2;
    localparam int BYTES_PER_UNIT = 3;
    localparam int LINE_PIXELS    = 320;

    // Controller registers on APB.
    localparam logic [11:0] APB_CTRL   = 12'h000;
    localparam logic [11:0] APB_STATUS = 12'h004;
    localparam logic [11:0] APB_CMD    = 12'h008;
    localparam logic [11:0] APB_LOT    = 12'h00C;
    localparam int CTRL_START = 0;
    localparam int CTRL_STREAM = 1;
    localparam int ST_BUSY = 9;
    localparam int ST_NACK = 10;
    localparam int ST_PEND = 11;

    typedef enum logic [3:0] {
        DEV_HWPREP = 4'h1,
        DEV_SENS_SB = 4'h2,
        DEV_SW_SB = 4'h4,
        DEV_STREAM = 4'h8
    } tss_dev_state_t;
endpackage

// File: tss_sensor_end.sv
`timescale 1ns/10ps
module tss_sensor_end
    import tss_pkg::*;
#(
    parameter int LINE_PIX = LINE_PIXELS
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    tss_link_if.dev          link,
    input  wire logic [15:0] integCycles,
    output logic             streaming,
    output logic             laneFour,
    output logic             frameTrig,
    output logic             firstData,
    output logic [15:0]      pktBytes,
    output tss_dev_state_t   devState
);
    localparam logic [15:0] LINE_BYTES = 16'((LINE_PIX / PIX_PER_UNIT) * BYTES_PER_UNIT);

    typedef struct packed {
        logic           rstMeta, rstSync, sclMeta, sclSync, sdaMeta, sdaSync;
        logic           sclPrev, sdaPrev;
        tss_dev_state_t state;
        logic           active, ackDrv;
        logic [3:0]     bitCnt;
        logic [1:0]     byteIdx;
        logic [7:0]     shreg;
        logic [15:0]    regAddr;
        logic [7:0]     standbyReg, streamReg, laneReg;
        logic [15:0]    dataCnt;
        logic           cntRun, frameTrig, firstData;
        logic [15:0]    pktBytes;
    } tss_dev_t;

    tss_dev_t r_reg;
    tss_dev_t r_next;
    logic     sclRise, sclFall, startCond, stopCond;

    always_comb begin
        r_next = r_reg;
        r_next.rstMeta = link.resetPinN;
        r_next.rstSync = r_reg.rstMeta;
        r_next.sclMeta = link.scl;
        r_next.sclSync = r_reg.sclMeta;
        r_next.sdaMeta = link.sda;
        r_next.sdaSync = r_reg.sdaMeta;
        r_next.sclPrev = r_reg.sclSync;
        r_next.sdaPrev = r_reg.sdaSync;
        r_next.frameTrig = 1'h0;
        r_next.firstData = 1'h0;
        sclRise = r_reg.sclSync && !r_reg.sclPrev;
        sclFall = !r_reg.sclSync && r_reg.sclPrev;
        startCond = r_reg.sclSync && r_reg.sclPrev && !r_reg.sdaSync && r_reg.sdaPrev;
        stopCond = r_reg.sclSync && r_reg.sclPrev && r_reg.sdaSync && !r_reg.sdaPrev;
        if (!r_reg.rstSync) begin
            // Pin low: bus silent and the standby, stream and lane registers back to reset value. [R23]
            r_next.state = DEV_HWPREP;
            r_next.active = 1'h0;
            r_next.ackDrv = 1'h0;
            r_next.standbyReg = STANDBY_RST;
            r_next.streamReg = STREAM_RST;
            r_next.laneReg = LANE_RST;
            r_next.cntRun = 1'h0;
        end else begin
            if (startCond) begin
                r_next.active = 1'h1;
                r_next.bitCnt = 4'h0;
                r_next.byteIdx = 2'h0;
                r_next.ackDrv = 1'h0;
            end else if (stopCond) begin
                r_next.active = 1'h0;
                r_next.ackDrv = 1'h0;
            end else if (r_reg.active && sclRise && r_reg.bitCnt < 4'h8) begin
                r_next.shreg = {r_reg.shreg[6:0], r_reg.sdaSync};
                r_next.bitCnt = r_reg.bitCnt + 4'h1;
            end else if (r_reg.active && sclFall && r_reg.ackDrv) begin
                r_next.ackDrv = 1'h0;
                r_next.bitCnt = 4'h0;
                if (r_reg.byteIdx != 2'h3) begin
                    r_next.byteIdx = r_reg.byteIdx + 2'h1;
                end
            end else if (r_reg.active && sclFall && r_reg.bitCnt == 4'h8) begin
                r_next.ackDrv = 1'h1;
                case (r_reg.byteIdx)
                    2'h0: begin
                        // Reads are not served, so a read request is refused.
                        if (r_reg.shreg[7:1] != SLAVE_ADDR || r_reg.shreg[0]) begin
                            r_next.active = 1'h0;
                            r_next.ackDrv = 1'h0;
                        end
                    end
                    2'h1: r_next.regAddr[15:8] = r_reg.shreg;
                    2'h2: r_next.regAddr[7:0] = r_reg.shreg;
                    default: begin
                        case (r_reg.regAddr)
                            REG_STANDBY: r_next.standbyReg = r_reg.shreg;
                            REG_STREAM: r_next.streamReg = r_reg.shreg;
                            REG_LANE: r_next.laneReg = r_reg.shreg;
                            default: r_next.regAddr = r_reg.regAddr;
                        endcase
                        r_next.regAddr = r_reg.regAddr + 16'h0001;
                    end
                endcase
            end

            case (r_reg.state)
                DEV_HWPREP: r_next.state = DEV_SENS_SB;
                DEV_SENS_SB: begin
                    if (!r_reg.standbyReg[CTL_BIT]) begin
                        r_next.state = DEV_SW_SB; // [R08]
                    end
                end
                DEV_SW_SB: begin
                    if (r_reg.standbyReg[CTL_BIT]) begin
                        r_next.state = DEV_SENS_SB;
                    end else if (r_reg.streamReg[CTL_BIT]) begin
                        r_next.state = DEV_STREAM; // [R15]
                        r_next.frameTrig = 1'h1; // [R22]
                        r_next.cntRun = 1'h1;
                        r_next.dataCnt = 16'h0000;
                        r_next.pktBytes = LINE_BYTES; // [R01]
                    end
                end
                DEV_STREAM: begin
                    if (!r_reg.streamReg[CTL_BIT] || r_reg.standbyReg[CTL_BIT]) begin
                        r_next.state = DEV_SW_SB;
                        r_next.cntRun = 1'h0;
                    end
                end
                default: r_next.state = DEV_HWPREP;
            endcase

            // First data after the integration time, well inside its bound. [R17]
            if (r_reg.cntRun) begin
                r_next.dataCnt = r_reg.dataCnt + 16'h0001;
                if (r_reg.dataCnt == integCycles) begin
                    r_next.firstData = 1'h1;
                    r_next.cntRun = 1'h0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            r_reg <= '0;
            r_reg.state <= DEV_HWPREP;
            r_reg.standbyReg <= STANDBY_RST;
            r_reg.streamReg <= STREAM_RST;
            r_reg.laneReg <= LANE_RST;
            r_reg.sclMeta <= 1'h1;
            r_reg.sclSync <= 1'h1;
            r_reg.sdaMeta <= 1'h1;
            r_reg.sdaSync <= 1'h1;
            r_reg.sclPrev <= 1'h1;
            r_reg.sdaPrev <= 1'h1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign link.devSdaOut = 1'h0;
    assign link.devSdaOen = !r_reg.ackDrv;
    assign streaming = r_reg.state == DEV_STREAM;
    assign laneFour = r_reg.laneReg[CTL_BIT]; // [R19]
    assign frameTrig = r_reg.frameTrig;
    assign firstData = r_reg.firstData;
    assign pktBytes = r_reg.pktBytes;
    assign devState = r_reg.state;
endmodule
